// >>> pipe_params.svh
/*
 pipeline and interrupt entry constants.
 assumes inclusion by bare name; definitions only.
*/
`ifndef PIPE_PARAMS_SVH
`define PIPE_PARAMS_SVH
// number of pipeline stages
`define PIPE_STAGES 8
// index of first fetch stage
`define FIRST_FETCH_IDX 0
// index of second decode stage, first committed stage
`define SECOND_DECODE_IDX 3
// instruction word width
`define INSN_W 32
// program address width
`define PC_W 32
// reset fetch address
`define RESET_PC 32'h0000_0000
// pc step per instruction
`define PC_STEP 32'h0000_0001
// number of interrupt lines
`define IRQ_LINES 16
// index width for interrupt lines
`define IRQ_IDX_W 4
`endif

// >>> pipe_pkg.sv
/*
 types shared by the pipeline interrupt entry block.
 assumes pipe_params.svh is on the include path.
*/
`include "pipe_params.svh"
package pipe_pkg;
	// one pipeline slot
	typedef struct packed {
		logic valid;
		logic [`PC_W-1:0] pc;
		logic [`INSN_W-1:0] insn;
	} slot_s;
	// retired instruction to the write-back side
	typedef struct packed {
		logic valid;
		logic [`PC_W-1:0] pc;
		logic [`INSN_W-1:0] insn;
	} retire_s;
	// interrupt entry request to the vector logic
	typedef struct packed {
		logic take;
		logic [`IRQ_IDX_W-1:0] line;
		logic [`PC_W-1:0] return_pc;
	} entry_s;
	// service state, gray coded along idle, drain, service
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DRAIN = 2'b01,
		ST_SERVICE = 2'b11
	} svc_e;
endpackage

// >>> irq_pick.sv
/*
 pending interrupt latch and fixed priority pick.
 assumes synchronous request lines, one clock, rstn synchronous active low.
*/
`timescale 1ns/1ps
`include "pipe_params.svh"
module irq_pick
	import pipe_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// request side
	input wire logic [`IRQ_LINES-1:0] irq_req,
	input wire logic [`IRQ_LINES-1:0] irq_enable,
	// acknowledge of the picked line
	input wire logic ack,
	input wire logic [`IRQ_IDX_W-1:0] ack_line,
	// pick result
	output logic any_pending,
	output logic [`IRQ_IDX_W-1:0] pick_line,
	output logic [`IRQ_LINES-1:0] pending
);
	// pending flags
	logic [`IRQ_LINES-1:0] pending_reg;
	logic [`IRQ_LINES-1:0] pending_next;
	logic [`IRQ_LINES-1:0] gated;

	// lowest index wins
	function automatic logic [`IRQ_IDX_W-1:0] low_index(input logic [`IRQ_LINES-1:0] v);
		logic [`IRQ_IDX_W-1:0] r;
		r = '0;
		for (int i = `IRQ_LINES-1; i >= 0; i--) begin
			if (v[i]) begin
				r = i[`IRQ_IDX_W-1:0];
			end
		end
		return r;
	endfunction

	// ack clears, a new request in the same cycle wins
	always_comb begin
		pending_next = pending_reg;
		if (ack) begin
			pending_next[ack_line] = 1'b0;
		end
		pending_next = pending_next | irq_req;
	end

	// latch requests
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pending_reg <= '0;
		end else begin
			pending_reg <= pending_next;
		end
	end

	assign gated = pending_reg & irq_enable;
	assign any_pending = |gated;
	assign pick_line = low_index(gated);
	assign pending = pending_reg;
endmodule

// >>> pipe_irq_ctrl.sv
/*
 eight stage pipeline control with maskable interrupt entry.
 assumes one clock, synchronous inputs, instruction memory answering fetch in the same cycle.
*/
`timescale 1ns/1ps
`include "pipe_params.svh"
module pipe_irq_ctrl
	import pipe_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// instruction fetch
	input wire logic [`INSN_W-1:0] fetch_insn,
	output logic [`PC_W-1:0] fetch_pc,
	// interrupt requests
	input wire logic [`IRQ_LINES-1:0] irq_req,
	input wire logic [`IRQ_LINES-1:0] irq_enable,
	// software nesting override, lets requests in during service
	input wire logic nest_allow,
	// return from the service routine, one cycle pulse
	input wire logic irq_return,
	// outputs
	output retire_s retire,
	output entry_s entry,
	output logic in_service,
	output logic [`PIPE_STAGES-1:0] stage_valid
);
	// pipeline slots, index 0 is first fetch stage
	slot_s pipe_reg [`PIPE_STAGES];
	logic [`PC_W-1:0] pc_reg;
	logic [`PC_W-1:0] pc_next;
	svc_e state_reg;
	svc_e state_next;
	logic [`IRQ_IDX_W-1:0] line_reg;
	logic [`PC_W-1:0] ret_pc_reg;
	retire_s retire_reg;
	entry_s entry_reg;
	logic in_service_reg;
	logic [`PIPE_STAGES-1:0] stage_valid_reg;
	// picker interface
	logic any_pending;
	logic [`IRQ_IDX_W-1:0] pick_line;
	logic accept;
	logic drained;
	logic fetch_on;
	logic [`PIPE_STAGES-1:0] valid_vec;

	// committed part empty
	function automatic logic committed_empty(input logic [`PIPE_STAGES-1:0] v);
		return ~|v[`PIPE_STAGES-1:`SECOND_DECODE_IDX];
	endfunction

	// oldest flushed pc, the restart address
	function automatic logic [`PC_W-1:0] oldest_young_pc(input logic [`PIPE_STAGES-1:0] v,
			input logic [`PC_W-1:0] pcs [`PIPE_STAGES], input logic [`PC_W-1:0] fpc);
		logic [`PC_W-1:0] r;
		r = fpc;
		for (int i = 0; i < `SECOND_DECODE_IDX; i++) begin
			if (v[i]) begin
				r = pcs[i];
			end
		end
		return r;
	endfunction

	logic [`PC_W-1:0] slot_pcs [`PIPE_STAGES];
	always_comb begin
		for (int i = 0; i < `PIPE_STAGES; i++) begin
			valid_vec[i] = pipe_reg[i].valid;
			slot_pcs[i] = pipe_reg[i].pc;
		end
	end

	irq_pick u_pick (
		.clk(clk),
		.rstn(rstn),
		.irq_req(irq_req),
		.irq_enable(irq_enable),
		.ack(accept),
		.ack_line(pick_line),
		.any_pending(any_pending),
		.pick_line(pick_line),
		.pending()
	);

	// accept only when idle, or in service with nesting allowed
	assign accept = any_pending && ((state_reg == ST_IDLE) || ((state_reg == ST_SERVICE) && nest_allow));
	// fetch stops from acceptance until the committed stages drain
	assign fetch_on = (state_reg != ST_DRAIN) && !accept;
	assign drained = committed_empty(valid_vec);

	// service state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					state_next = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				// committed stages run out, no stall anywhere
				if (drained) begin
					state_next = ST_SERVICE;
				end
			end
			ST_SERVICE: begin
				if (accept) begin
					state_next = ST_DRAIN;
				end else if (irq_return) begin
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// fetch address, restart at first fetch on entry and return
	always_comb begin
		pc_next = pc_reg;
		if (accept) begin
			pc_next = oldest_young_pc(valid_vec, slot_pcs, pc_reg);
		end else if (state_reg == ST_SERVICE && irq_return) begin
			pc_next = ret_pc_reg;
		end else if (fetch_on) begin
			pc_next = pc_reg + `PC_STEP;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pc_reg <= `RESET_PC;
		end else begin
			pc_reg <= pc_next;
		end
	end

	// saved line and return address
	always_ff @(posedge clk) begin
		if (!rstn) begin
			line_reg <= '0;
			ret_pc_reg <= `RESET_PC;
		end else if (accept) begin
			line_reg <= pick_line;
			ret_pc_reg <= oldest_young_pc(valid_vec, slot_pcs, pc_reg);
		end
	end

	// eight stage shift, flush of uncommitted stages on accept
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < `PIPE_STAGES; i++) begin
				pipe_reg[i] <= '0;
			end
		end else begin
			// first fetch stage loads every cycle, valid only while fetching
			pipe_reg[`FIRST_FETCH_IDX] <= '{valid: fetch_on, pc: pc_reg, insn: fetch_insn};
			for (int i = 1; i < `PIPE_STAGES; i++) begin
				if (accept && i <= `SECOND_DECODE_IDX) begin
					pipe_reg[i] <= '0;
				end else begin
					pipe_reg[i] <= pipe_reg[i-1];
				end
			end
		end
	end

	// registered outputs
	always_ff @(posedge clk) begin
		if (!rstn) begin
			retire_reg <= '0;
			entry_reg <= '0;
			in_service_reg <= 1'b0;
			stage_valid_reg <= '0;
		end else begin
			retire_reg <= '{valid: pipe_reg[`PIPE_STAGES-1].valid,
				pc: pipe_reg[`PIPE_STAGES-1].pc, insn: pipe_reg[`PIPE_STAGES-1].insn};
			entry_reg <= '{take: (state_reg == ST_DRAIN) && drained, line: line_reg, return_pc: ret_pc_reg};
			in_service_reg <= (state_next != ST_IDLE);
			stage_valid_reg <= valid_vec;
		end
	end

	assign fetch_pc = pc_reg;
	assign retire = retire_reg;
	assign entry = entry_reg;
	assign in_service = in_service_reg;
	assign stage_valid = stage_valid_reg;

	// named steps of interrupt entry
	sequence accept_s;
		accept && state_reg == ST_IDLE && drained;
	endsequence

	property flush_young_p;
		@(posedge clk) disable iff (!rstn) accept |=> !pipe_reg[0].valid && !pipe_reg[1].valid && !pipe_reg[2].valid
			&& !pipe_reg[`SECOND_DECODE_IDX].valid;
	endproperty

	flush_young_a: assert property (flush_young_p) else $error("uncommitted stage survived entry");

	committed_keep_a: assert property (@(posedge clk) disable iff (!rstn)
		accept && pipe_reg[`SECOND_DECODE_IDX].valid |=> pipe_reg[`SECOND_DECODE_IDX+1].valid)
		else $error("committed instruction lost on entry");

	stage_shift_a: assert property (@(posedge clk) disable iff (!rstn)
		pipe_reg[4].valid |-> ##3 pipe_reg[7].valid) else $error("stage count broken");

	// one edge into drain, then up to five edges to empty the committed stages
	drain_time_a: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == ST_IDLE && accept |-> ##[2:6] state_reg == ST_SERVICE)
		else $error("drain did not end in time");

	empty_entry_a: assert property (@(posedge clk) disable iff (!rstn)
		accept_s |=> state_reg == ST_DRAIN ##1 state_reg == ST_SERVICE)
		else $error("entry latency not fixed");

	hold_pending_a: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == ST_SERVICE && !nest_allow |-> !accept) else $error("request taken during service");

	// restart address reaches the first fetch stage, empty only if a held request is taken at once
	restart_fetch_a: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == ST_SERVICE && irq_return && !accept |=> fetch_pc == $past(ret_pc_reg)
		##1 pipe_reg[`FIRST_FETCH_IDX].pc == $past(ret_pc_reg, 2)
		&& (pipe_reg[`FIRST_FETCH_IDX].valid || $past(accept)))
		else $error("return did not restart at first fetch");

	no_fetch_drain_a: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == ST_DRAIN |=> !pipe_reg[0].valid) else $error("fetch during drain");
endmodule

// >>> irq_source.sv
/*
 request source model standing in front of the interrupt entry block.
 assumes the bench calls its tasks; changes land on the falling edge.
*/
`timescale 1ns/1ps
`include "pipe_params.svh"
module irq_source
	import pipe_pkg::*;
(
	// clock
	input wire logic clk,
	// request side
	output logic [`IRQ_LINES-1:0] irq_req,
	output logic [`IRQ_LINES-1:0] irq_enable
);
	// idle: no request, all lines enabled
	initial begin
		irq_req = '0;
		irq_enable = '1;
	end
	// one-cycle request pulse on a line
	task pulse(input int k);
		@(negedge clk);
		irq_req <= `IRQ_LINES'(1) << k;
		@(negedge clk);
		irq_req <= '0;
	endtask
	// per-line mask, applied off the sampling edge
	task set_mask(input logic [`IRQ_LINES-1:0] m);
		@(negedge clk);
		irq_enable <= m;
	endtask
endmodule

// >>> testbench.sv
/*
 self-checking bench for the pipeline interrupt entry block.
 assumes irq_source.sv and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "pipe_params.svh"
module testbench;
	import pipe_pkg::*;
	logic clk = 0, rstn = 0, nest_allow = 0, irq_return = 0;
	logic [`IRQ_LINES-1:0] irq_req, irq_enable;
	logic [`PC_W-1:0] fetch_pc, last_pc, ret_pc;
	logic [`PIPE_STAGES-1:0] stage_valid;
	retire_s retire;
	entry_s entry;
	logic in_service;
	int fails = 0, n_checks = 0, cyc = 0, lat0, lat;
	// instruction memory answers in the same cycle
	wire [`INSN_W-1:0] fetch_insn = fetch_pc ^ 32'h5a5a_0000;
	always #5 clk = ~clk;
	irq_source irq_source_i (.clk(clk), .irq_req(irq_req), .irq_enable(irq_enable));
	pipe_irq_ctrl pipe_irq_ctrl_i (.clk(clk), .rstn(rstn), .fetch_insn(fetch_insn), .fetch_pc(fetch_pc),
		.irq_req(irq_req), .irq_enable(irq_enable), .nest_allow(nest_allow), .irq_return(irq_return),
		.retire(retire), .entry(entry), .in_service(in_service), .stage_valid(stage_valid));
	// last retired pc, plus hang guard
	always @(negedge clk) begin
		cyc++;
		if (retire.valid === 1'b1)
			last_pc <= retire.pc;
		if (cyc == 5000) begin
			fails++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task check(input logic [`PC_W-1:0] seen, input logic [`PC_W-1:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// wait for entry, bounded
	task wait_take(output int n);
		n = 0;
		while (entry.take !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		check(entry.take, 1, "entry taken");
	endtask
	// no entry may appear for n cycles
	task quiet(input int n);
		logic seen;
		seen = 0;
		repeat (n) begin
			@(negedge clk);
			if (entry.take === 1'b1)
				seen = 1;
		end
		check(seen, 0, "entry while held");
	endtask
	// steady flow fills all stages
	task t_flow();
		repeat (12) @(negedge clk);
		check(stage_valid, 8'hff, "stages full");
		check(retire.valid, 1, "retire flow");
		check(retire.insn, retire.pc ^ 32'h5a5a_0000, "retired word");
	endtask
	// entry from full pipeline
	task t_irq(input int k, output int n);
		irq_source_i.pulse(k);
		wait_take(n);
		check(entry.line, k, "entry line");
		check(entry.return_pc, last_pc + `PC_STEP, "restart after committed");
		check(in_service, 1, "in service");
		ret_pc = entry.return_pc;
	endtask
	// return restarts fetch at restart pc
	task t_return();
		irq_return <= 1;
		@(negedge clk);
		irq_return <= 0;
		check(fetch_pc, ret_pc, "refetch pc");
		check(in_service, 0, "service ended");
		@(negedge clk);
		check(stage_valid[0], 1, "first fetch stage");
	endtask
	// mid-run reset, then entry while the committed stages are empty
	task t_reset_entry(input int lat_empty);
		int n;
		rstn <= 0;
		nest_allow <= 0;
		repeat (2) @(negedge clk);
		check(in_service, 0, "reset ends service");
		check(stage_valid, 0, "reset empties stages");
		rstn <= 1;
		irq_source_i.pulse(4);
		wait_take(n);
		check(entry.line, 4, "entry after reset");
		check(n, lat_empty, "same latency with committed stages empty");
		check(entry.return_pc, `RESET_PC, "restart at oldest flushed");
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rstn <= 1;
		t_flow();
		t_irq(2, lat0);
		check(lat0 <= 9, 1, "entry bound");
		t_return();
		repeat (20) @(negedge clk);
		t_irq(2, lat);
		check(lat, lat0, "same latency");
		irq_source_i.pulse(1);
		quiet(12);
		t_return();
		wait_take(lat);
		check(entry.line, 1, "held request taken");
		ret_pc = entry.return_pc;
		t_return();
		irq_source_i.set_mask(16'hfff7);
		irq_source_i.pulse(3);
		quiet(15);
		irq_source_i.set_mask(16'hffff);
		wait_take(lat);
		check(entry.line, 3, "unmasked taken");
		nest_allow <= 1;
		irq_source_i.pulse(0);
		wait_take(lat);
		check(entry.line, 0, "nested taken");
		check(lat < 40, 1, "nested bound");
		t_reset_entry(lat);
		end_of_test();
	end
endmodule
